// File: hdl/mgmt_map_pkg.sv
package mgmt_map_pkg;

  // Core clock rate and the timing figures that depend on it.
  localparam int unsigned CORE_CLK_HZ = 40_000_000;
  localparam int unsigned RESTART_MIN_NS = 2000;
  localparam int unsigned RESTART_MIN_CYC = (RESTART_MIN_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned INIT_MAX_MS = 2000;
  localparam int unsigned INIT_MAX_CYC = INIT_MAX_MS * (CORE_CLK_HZ / 1000);
  localparam int unsigned INIT_CNT_W = 27;

  // Bus device address in its 8-bit write form.
  localparam logic [7:0] DEV_ADDR = 8'hA0;

  // Lower memory map byte offsets.
  localparam logic [7:0] TYPE_ID_ADDR = 8'h00;
  localparam logic [7:0] MODULE_STATUS_ADDR = 8'h01;
  localparam logic [7:0] MODULE_STATUS_HI_ADDR = 8'h02;
  localparam logic [7:0] EVENT_FLAGS_ADDR = 8'h03;
  localparam logic [7:0] MODULE_MONITOR_ADDR = 8'h16;
  localparam logic [7:0] LANE_MONITOR_ADDR = 8'h22;
  localparam logic [7:0] RSVD_RO_ADDR = 8'h52;
  localparam logic [7:0] CONTROL_ADDR = 8'h56;
  localparam logic [7:0] RSVD_RW_A_ADDR = 8'h62;
  localparam logic [7:0] EVENT_MASKS_ADDR = 8'h64;
  localparam logic [7:0] RSVD_RW_B_ADDR = 8'h6B;
  localparam logic [7:0] RSVD_RW_C_ADDR = 8'h77;
  localparam logic [7:0] RSVD_RW_D_ADDR = 8'h7B;
  localparam logic [7:0] PAGE_SELECT_ADDR = 8'h7F;
  localparam logic [7:0] UPPER_BASE_ADDR = 8'h80;

  // Writable window runs from the first control byte up to the page selector.
  localparam int unsigned RW_BYTES = 42;

  // Field positions.
  localparam int unsigned INIT_PENDING_BIT = 0;
  localparam int unsigned RESTART_DONE_BIT = 0;
  localparam int unsigned FAULT_FLAG_BIT = 1;

  // Reset values.
  localparam logic [7:0] RW_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

endpackage

// File: hdl/module_mgmt_sideband_map.sv
`timescale 1ns/1ps

// Overview of operation
// R01 - With select low, answer bus transactions addressed to this module.
// R02 - With select high, ignore all bus traffic; select defaults high.
// R03 - A qualified low pulse on restart returns all user settings to defaults.
// R04 - Restart low must last at least 2 us to count.
// R05 - Initialization time starts at the restart rising edge.
// R06 - Module is fully functional within 2000 ms of power-on or restart.
// R07 - Host ignores status bits until reset completion is signalled.
// R08 - Signal completion by attention low with init-pending bit clear.
// R09 - Raise completion attention after power-up without a restart pulse.
// R10 - Low-power request high enters the reduced-power state.
// R11 - Presence output is tied low while inserted.
// R12 - Attention pulled low to report fault or critical status.
// R13 - Host reads flag bytes after attention to find the cause.
// R14 - Memory is 128 fixed lower bytes plus paged upper range; the upper range here has no storage and reads as zero.
// R15 - Byte 127 selects the upper page; here it is only stored and selects nothing.
// R16 - Answer at device address A0h for all memory accesses.
// R17 - Read-only flags 3-21, module monitors 22-33, lane monitors 34-81.
// R18 - Writable control bytes 86-97 and mask bytes 100-106.
// R19 - Writes to read-only bytes are acknowledged but change nothing.
module module_mgmt_sideband_map
  import mgmt_map_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_MAX_CYC,
  parameter logic [7:0] TYPE_ID = 8'h5A // Arbitrary value.
) (
  // Core clock and power-on reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus oversampling clock.
  input wire logic link_clk,
  // Sideband pins.
  input wire logic bus_select_n,
  input wire logic module_restart_n,
  input wire logic low_power_request,
  input wire logic fault_alarm,
  output logic presence_n,
  output logic attention_n,
  output logic low_power_state,
  // Two-wire bus pins.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);

  // Cycle figures above this width cannot be counted.
  if (INIT_CYCLES < 1 || INIT_CYCLES > (2 ** INIT_CNT_W) - 1) begin : g_bad_init
    $error("INIT_CYCLES out of range");
  end

  // The glitch filter counts in eight bits, so the minimum pulse must fit.
  if (RESTART_MIN_CYC < 1 || RESTART_MIN_CYC > 255) begin : g_bad_restart
    $error("RESTART_MIN_CYC out of range");
  end

  // The writable array must span exactly the first control byte up to the page selector.
  if (RW_BYTES != int'(PAGE_SELECT_ADDR) - int'(CONTROL_ADDR) + 1) begin : g_bad_window
    $error("RW_BYTES does not match the writable window");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: restart qualification and initialization timing.

  logic [1:0] restart_sync;
  logic [1:0] lowpwr_sync;
  logic [7:0] low_cnt;
  logic restart_armed;
  logic restart_busy;
  logic [INIT_CNT_W-1:0] init_cnt;
  logic init_pending;

  // Pins are brought into the core clock through two flip-flops.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_sync <= 2'h3;
      lowpwr_sync <= 2'h0;
    end else begin
      restart_sync <= {restart_sync[0], module_restart_n};
      lowpwr_sync <= {lowpwr_sync[0], low_power_request};
    end
  end

  // A low level shorter than the minimum is a glitch and is dropped.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 8'h00;
      restart_armed <= 1'b0;
    end else if (restart_sync[1]) begin
      low_cnt <= 8'h00;
      restart_armed <= 1'b0;
    end else if (low_cnt < 8'(RESTART_MIN_CYC)) begin
      low_cnt <= low_cnt + 8'h01; // R04
    end else begin
      restart_armed <= 1'b1; // R03
    end
  end

  // Settings are held at default for as long as a qualified pulse lasts.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_busy <= 1'b0;
    end else begin
      restart_busy <= restart_armed && !restart_sync[1]; // R03
    end
  end

  // The timer reloads while a qualified restart is held and only runs from release on.
  // Holding restart longer only delays the start; it never shortens the interval.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt <= INIT_CNT_W'(INIT_CYCLES); // R09
      init_pending <= 1'b1;
    end else if (restart_busy) begin
      init_cnt <= INIT_CNT_W'(INIT_CYCLES); // R05
      init_pending <= 1'b1;
    end else if (init_cnt != '0) begin
      init_cnt <= init_cnt - 1'b1; // R06
      init_pending <= 1'b1;
    end else begin
      init_pending <= 1'b0; // R06
    end
  end

  // Low power follows the request; presence is a constant ground.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_power_state <= 1'b0;
      presence_n <= 1'b0;
    end else begin
      low_power_state <= lowpwr_sync[1]; // R10
      presence_n <= 1'b0; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: pin synchronisers and level crossings from the core.

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] sel_sync;
  logic [1:0] fault_sync;
  logic [1:0] busy_sync;
  logic [1:0] pend_sync;
  logic scl_prev;
  logic sda_prev;
  logic pend_prev;

  // Core levels change slowly, so two flip-flops are enough to carry them.
  // Edge detectors start at the idle high level, so reset release shows no false edge.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sel_sync <= 2'h3;
      fault_sync <= 2'h0;
      busy_sync <= 2'h0;
      pend_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      pend_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      sel_sync <= {sel_sync[0], bus_select_n};
      fault_sync <= {fault_sync[0], fault_alarm};
      busy_sync <= {busy_sync[0], restart_busy};
      pend_sync <= {pend_sync[0], init_pending};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
      pend_prev <= pend_sync[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic init_done;

  // Bus conditions are taken from the settled copies only.
  assign scl_rise = scl_sync[1] && !scl_prev;
  assign scl_fall = !scl_sync[1] && scl_prev;
  assign bus_start = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
  assign bus_stop = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];
  assign init_done = pend_prev && !pend_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Memory map decoding.

  // Only the control, mask, reserved read/write and page select bytes take writes.
  function automatic logic is_writable(input logic [7:0] a);
    return (a >= CONTROL_ADDR) && (a <= PAGE_SELECT_ADDR); // R18
  endfunction

  // Index of a byte inside the writable window; callers check writability first.
  function automatic logic [5:0] rw_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - CONTROL_ADDR;
    return d[5:0];
  endfunction

  // Storage for the writable window, one flip-flop byte per address.
  logic [7:0] rw_mem [RW_BYTES];
  logic [7:0] event_flags;
  logic [7:0] mem_ptr;
  logic [7:0] rd_byte;

  // Read mux; monitors, read-only reserved and upper page bytes read as zero.
  // Upper pages have no storage behind them; the page selector is only stored.
  always_comb begin
    rd_byte = 8'h00; // R17
    if (mem_ptr == TYPE_ID_ADDR) begin
      rd_byte = TYPE_ID;
    end else if (mem_ptr == MODULE_STATUS_HI_ADDR) begin
      rd_byte = 8'h00;
      rd_byte[INIT_PENDING_BIT] = pend_sync[1]; // R08
    end else if (mem_ptr == EVENT_FLAGS_ADDR) begin
      rd_byte = event_flags; // R17
    end else if (is_writable(mem_ptr)) begin
      rd_byte = rw_mem[rw_index(mem_ptr)]; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire slave.

  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_OFFS, ST_WDATA, ST_RDATA} bus_state_e;

  bus_state_e bus_state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic wr_strobe;
  logic rd_strobe;
  logic [7:0] rd_addr;
  logic [7:0] rd_sent;

  // Shift on rising clock, drive on falling clock; bit 8 is the ack slot.
  // Limitation: each bus clock half period must span at least eight link clocks.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= ST_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      mem_ptr <= 8'h00;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      rd_addr <= 8'h00;
      rd_sent <= 8'h00;
    end else begin
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      sda_out <= 1'b0;
      if (sel_sync[1] || bus_stop) begin
        bus_state <= ST_IDLE; // R02
        sda_oe_n <= 1'b1;
      end else if (bus_start) begin
        bus_state <= ST_DEV; // R01
        bit_cnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (bus_state != ST_IDLE && scl_rise) begin
        if (bit_cnt < 4'h8) begin
          rx_shift <= {rx_shift[6:0], sda_sync[1]};
        end else if (bus_state == ST_RDATA && sda_sync[1]) begin
          bus_state <= ST_IDLE;
        end
        bit_cnt <= bit_cnt + 4'h1;
      end else if (bus_state != ST_IDLE && scl_fall) begin
        if (bit_cnt == 4'h8) begin
          unique case (bus_state)
            ST_DEV: begin
              if (rx_shift[7:1] == DEV_ADDR[7:1]) begin
                sda_oe_n <= 1'b0; // R16
                bus_state <= rx_shift[0] ? ST_RDATA : ST_OFFS;
              end else begin
                bus_state <= ST_IDLE;
              end
            end
            ST_OFFS: begin
              sda_oe_n <= 1'b0;
              mem_ptr <= rx_shift;
              bus_state <= ST_WDATA;
            end
            ST_WDATA: begin
              sda_oe_n <= 1'b0; // R19
              wr_strobe <= 1'b1;
            end
            ST_RDATA: begin
              sda_oe_n <= 1'b1;
            end
            ST_IDLE: begin
              sda_oe_n <= 1'b1;
            end
          endcase
        end else if (bit_cnt == 4'h9) begin
          bit_cnt <= 4'h0;
          if (bus_state == ST_RDATA) begin
            sda_oe_n <= rd_byte[7];
            tx_shift <= {rd_byte[6:0], 1'b0};
            rd_strobe <= 1'b1;
            // The pointer moves on at this edge, so the byte and its address are kept for the clear.
            rd_addr <= mem_ptr;
            rd_sent <= rd_byte;
            mem_ptr <= mem_ptr + 8'h01;
          end else begin
            sda_oe_n <= 1'b1;
          end
        end else if (bus_state == ST_RDATA && bit_cnt != 4'h0) begin
          sda_oe_n <= tx_shift[7];
          tx_shift <= {tx_shift[6:0], 1'b0};
        end
      end else if (wr_strobe) begin
        mem_ptr <= mem_ptr + 8'h01;
      end
    end
  end

  // Writable bytes return to default while a restart is held.
  for (genvar i = 0; i < RW_BYTES; i++) begin : g_rw
    always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
        rw_mem[i] <= RW_RESET;
      end else if (busy_sync[1]) begin
        rw_mem[i] <= RW_RESET; // R03
      end else if (wr_strobe && is_writable(mem_ptr) && rw_index(mem_ptr) == 6'(i)) begin
        rw_mem[i] <= rx_shift; // R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags and attention.

  // Set and clear masks for the flag register.
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  // Only the bits that went out on the bus clear; a new event in the same cycle is kept.
  always_comb begin
    flag_set = 8'h00;
    flag_set[RESTART_DONE_BIT] = init_done; // R09
    flag_set[FAULT_FLAG_BIT] = fault_sync[1];
    flag_clr = (rd_strobe && rd_addr == EVENT_FLAGS_ADDR) ? rd_sent : 8'h00; // R13
  end

  // A restart in progress wipes every flag along with the settings.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_flags <= FLAGS_RESET;
    end else if (busy_sync[1]) begin
      event_flags <= FLAGS_RESET;
    end else begin
      event_flags <= (event_flags & ~flag_clr) | flag_set;
    end
  end

  // Attention pulls low for any unmasked flag and stays until it is read.
  // Masked events still set their flag, so unmasking raises attention at once.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      attention_n <= 1'b1;
    end else begin
      attention_n <= (event_flags & ~rw_mem[rw_index(EVENT_MASKS_ADDR)]) == 8'h00; // R12
    end
  end

endmodule

// File: verification/mgmt_sideband_checker.sv
`timescale 1ns/1ps
module mgmt_sideband_checker
  import mgmt_map_pkg::*;
(
  // Clocks and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // Sideband pins.
  input wire logic bus_select_n,
  input wire logic module_restart_n,
  input wire logic low_power_request,
  input wire logic fault_alarm,
  input wire logic presence_n,
  input wire logic attention_n,
  input wire logic low_power_state,
  // Two-wire bus pins.
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  logic [7:0] low_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // Length of the current restart low stretch; it saturates so a long hold never wraps.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 8'h00;
    end else if (module_restart_n) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hFF) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  // A few cycles of margin cover the pin synchroniser.
  sequence s_long_restart;
    !module_restart_n && (int'(low_cnt) > RESTART_MIN_CYC + 3) ##1 module_restart_n;
  endsequence
  sequence s_released;
    $rose(rst_n);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_presence_tied_low: assert property (@(posedge core_clk) disable iff (!rst_n) presence_n == 1'b0)
    else $error("presence pin not low");
  a_data_pull_only: assert property (@(posedge link_clk) disable iff (!rst_n) sda_out == 1'b0)
    else $error("data pin driven high");
  a_lp_enter: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(low_power_request) |-> ##[1:4] low_power_state) else $error("low power not entered");
  a_lp_leave: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(low_power_request) |-> ##[1:4] !low_power_state) else $error("low power not left");
  a_powerup_init_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_released |-> attention_n [*8]) else $error("attention early after power-up");
  a_restart_init_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_long_restart |=> attention_n [*8]) else $error("attention early after restart");
  a_deselect_released: assert property (@(posedge link_clk) disable iff (!rst_n)
    bus_select_n [*5] |-> sda_oe_n) else $error("data pulled while deselected");
  a_ack_scl_low: assert property (@(posedge link_clk) disable iff (!rst_n)
    $changed(sda_oe_n) |-> !scl_in) else $error("data changed with clock high");
endmodule

// File: verification/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model
  import mgmt_map_pkg::*;
(
  // Module side of the data line.
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Wire levels.
  output logic scl,
  output logic sda
);
  localparam int HALF = 100;
  localparam int SETUP = 20;
  logic sda_drv;
  ////////////////////////////////////////////////////////////////////////////
  // Open-drain data line: the pull-up wins unless a party pulls low.
  assign sda = sda_drv & (sda_oe_n | sda_out);
  // The clock stands high outside frames.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Data moves only well after the clock fall so the module never sees a false start.
  task automatic start();
    #SETUP sda_drv = 1'b1;
    #(HALF - SETUP) scl = 1'b1;
    #HALF sda_drv = 1'b0;
    #HALF scl = 1'b0;
  endtask
  task automatic stop();
    #SETUP sda_drv = 1'b0;
    #(HALF - SETUP) scl = 1'b1;
    #HALF sda_drv = 1'b1;
    #HALF;
  endtask
  task automatic xfer_bit(input logic b, output logic r);
    #SETUP sda_drv = b;
    #(HALF - SETUP) scl = 1'b1;
    r = sda;
    #HALF scl = 1'b0;
  endtask
  // Bytes go MSB first; the ninth bit carries the acknowledge.
  task automatic xfer_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], q[i]);
    end
    xfer_bit(ack_in, nak);
  endtask
  task automatic write_byte(input logic [7:0] dev, input logic [7:0] off, input logic [7:0] d,
                            output logic [2:0] nak);
    logic [7:0] q;
    start();
    xfer_byte(dev, 1'b1, q, nak[2]);
    xfer_byte(off, 1'b1, q, nak[1]);
    xfer_byte(d, 1'b1, q, nak[0]);
    stop();
  endtask
  // Pointer set by a write, then a repeated start; one byte read and ended with a nak.
  task automatic read_byte(input logic [7:0] off, output logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic [3:0] n;
    start();
    xfer_byte(DEV_ADDR, 1'b1, q, n[3]);
    xfer_byte(off, 1'b1, q, n[2]);
    start();
    xfer_byte(DEV_ADDR | 8'h01, 1'b1, q, n[1]);
    xfer_byte(8'hFF, 1'b1, d, n[0]);
    stop();
    nak = |n[3:1];
  endtask
endmodule

// File: verification/tb_module_mgmt_sideband_map.sv
`timescale 1ns/1ps
module tb_module_mgmt_sideband_map;
  import mgmt_map_pkg::*;
  localparam int unsigned INIT_SIM = 2000;
  localparam logic [7:0] TYPE_ID_SIM = 8'h3C; // Arbitrary value.
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic bus_select_n = 1'b0;
  logic module_restart_n = 1'b1;
  logic low_power_request = 1'b0;
  logic fault_alarm = 1'b0;
  logic presence_n, attention_n, low_power_state, scl_in, sda_in, sda_out, sda_oe_n, nk;
  logic [7:0] rd;
  logic [2:0] nak;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  module_mgmt_sideband_map #(.INIT_CYCLES(INIT_SIM), .TYPE_ID(TYPE_ID_SIM)) dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .link_clk(link_clk),
    .bus_select_n(bus_select_n),
    .module_restart_n(module_restart_n),
    .low_power_request(low_power_request),
    .fault_alarm(fault_alarm),
    .presence_n(presence_n),
    .attention_n(attention_n),
    .low_power_state(low_power_state),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n)
  );
  host_bus_model host (.sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl(scl_in), .sda(sda_in));
  always #12.5 core_clk = ~core_clk;
  // Link clock starts off phase from the core clock.
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  // Cuts a hang short well past the expected run length.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors = errors + 1;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wait_att(input logic lvl, input int lim);
    for (int i = 0; i < lim && attention_n !== lvl; i++) @(posedge core_clk);
  endtask
  task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
    host.read_byte(off, rd, nk);
    check({7'h00, nk}, 8'h00);
    check(rd, exp);
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    host.write_byte(DEV_ADDR, off, d, nak);
    check({5'h00, nak}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic power_up();
    check({7'h00, presence_n}, 8'h00);
    rd_chk(MODULE_STATUS_HI_ADDR, 8'h01);
    check({7'h00, attention_n}, 8'h01);
    wait_att(1'b0, INIT_SIM);
    check({7'h00, attention_n}, 8'h00);
    rd_chk(MODULE_STATUS_HI_ADDR, 8'h00);
    rd_chk(EVENT_FLAGS_ADDR, 8'h01);
    check({7'h00, attention_n}, 8'h01);
    rd_chk(TYPE_ID_ADDR, TYPE_ID_SIM);
  endtask
  task automatic map_access();
    wr(CONTROL_ADDR, 8'hA5);
    wr(EVENT_MASKS_ADDR, 8'h3C);
    wr(PAGE_SELECT_ADDR, 8'h03);
    wr(LANE_MONITOR_ADDR, 8'h77);
    wr(RSVD_RO_ADDR, 8'h11);
    wr(UPPER_BASE_ADDR, 8'h22);
    rd_chk(CONTROL_ADDR, 8'hA5);
    rd_chk(EVENT_MASKS_ADDR, 8'h3C);
    rd_chk(PAGE_SELECT_ADDR, 8'h03);
    rd_chk(LANE_MONITOR_ADDR, 8'h00);
    rd_chk(RSVD_RO_ADDR, 8'h00);
    rd_chk(UPPER_BASE_ADDR, 8'h00);
  endtask
  task automatic select_and_address();
    host.write_byte(8'hA2, CONTROL_ADDR, 8'h00, nak);
    check({5'h00, nak}, 8'h07);
    @(posedge core_clk) bus_select_n <= 1'b1;
    cyc(2);
    host.write_byte(DEV_ADDR, CONTROL_ADDR, 8'h00, nak);
    check({5'h00, nak}, 8'h07);
    @(posedge core_clk) bus_select_n <= 1'b0;
    cyc(2);
    rd_chk(CONTROL_ADDR, 8'hA5);
  endtask
  task automatic low_power_and_fault();
    @(posedge core_clk) low_power_request <= 1'b1;
    cyc(5);
    check({7'h00, low_power_state}, 8'h01);
    low_power_request <= 1'b0;
    fault_alarm <= 1'b1;
    cyc(5);
    fault_alarm <= 1'b0;
    cyc(2);
    check({7'h00, low_power_state}, 8'h00);
    check({7'h00, attention_n}, 8'h00);
    rd_chk(EVENT_FLAGS_ADDR, 8'h02);
    check({7'h00, attention_n}, 8'h01);
    wr(EVENT_MASKS_ADDR, 8'h02);
    @(posedge core_clk) fault_alarm <= 1'b1;
    cyc(5);
    fault_alarm <= 1'b0;
    cyc(2);
    check({7'h00, attention_n}, 8'h01);
    rd_chk(EVENT_FLAGS_ADDR, 8'h02);
  endtask
  // A short pulse must leave settings alone; a long one clears them and restarts the timer.
  task automatic restart();
    @(posedge core_clk) module_restart_n <= 1'b0;
    cyc(RESTART_MIN_CYC / 2);
    module_restart_n <= 1'b1;
    cyc(4);
    rd_chk(CONTROL_ADDR, 8'hA5);
    @(posedge core_clk) module_restart_n <= 1'b0;
    cyc(RESTART_MIN_CYC + 20);
    module_restart_n <= 1'b1;
    cyc(INIT_SIM - 50);
    check({7'h00, attention_n}, 8'h01);
    wait_att(1'b0, 100);
    check({7'h00, attention_n}, 8'h00);
    rd_chk(CONTROL_ADDR, 8'h00);
    rd_chk(EVENT_MASKS_ADDR, 8'h00);
    rd_chk(EVENT_FLAGS_ADDR, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    rst_n <= 1'b1;
    cyc(2);
    power_up();
    map_access();
    select_and_address();
    low_power_and_fault();
    restart();
    test_done();
  end
endmodule

bind module_mgmt_sideband_map mgmt_sideband_checker chk (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .link_clk(link_clk),
  .bus_select_n(bus_select_n),
  .module_restart_n(module_restart_n),
  .low_power_request(low_power_request),
  .fault_alarm(fault_alarm),
  .presence_n(presence_n),
  .attention_n(attention_n),
  .low_power_state(low_power_state),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n)
);
